// *** src/ccm_pkg.sv ***
// ccm_pkg: constants and types shared by the cpu clock select and monitor block
package ccm_pkg;

  // ---------------------------------------------------------------------------
  // configuration codes on the three clock configuration pins
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CCM_CFG_MUL4     = 3'h7;
  localparam logic [2:0] CCM_CFG_MUL3     = 3'h6;
  localparam logic [2:0] CCM_CFG_MUL2     = 3'h5;
  localparam logic [2:0] CCM_CFG_MUL5     = 3'h4;
  localparam logic [2:0] CCM_CFG_DIRECT   = 3'h3;
  localparam logic [2:0] CCM_CFG_MUL1P5   = 3'h2;
  localparam logic [2:0] CCM_CFG_PRESCALE = 3'h1;
  localparam logic [2:0] CCM_CFG_MUL2P5   = 3'h0;
  localparam logic [2:0] CCM_CFG_RESET    = CCM_CFG_MUL4;

  // ---------------------------------------------------------------------------
  // cpu clock half periods per input period (twice the factor)
  // ---------------------------------------------------------------------------
  localparam int         CCM_HALF_W       = 4;
  localparam logic [3:0] CCM_HALF_MUL4    = 4'h8;
  localparam logic [3:0] CCM_HALF_MUL3    = 4'h6;
  localparam logic [3:0] CCM_HALF_MUL2    = 4'h4;
  localparam logic [3:0] CCM_HALF_MUL5    = 4'hA;
  localparam logic [3:0] CCM_HALF_MUL1P5  = 4'h3;
  localparam logic [3:0] CCM_HALF_MUL2P5  = 4'h5;
  localparam logic [3:0] CCM_HALF_NONE    = 4'h0;

  // ---------------------------------------------------------------------------
  // input clock monitor and period measurement
  // ---------------------------------------------------------------------------
  localparam int         CCM_MON_W        = 5;
  localparam logic [4:0] CCM_MON_OVERFLOW = 5'h10;
  localparam logic [4:0] CCM_MON_RESET    = 5'h00;
  localparam int         CCM_PER_W        = 16;
  localparam logic [15:0] CCM_PER_RESET   = 16'h0000;
  localparam logic [15:0] CCM_PER_MAX     = 16'hFFFF;

  // ---------------------------------------------------------------------------
  // clock generation mechanism
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCM_MODE_MULT     = 2'b00,
    CCM_MODE_DIRECT   = 2'b01,
    CCM_MODE_PRESCALE = 2'b10
  } ccm_mode_type;

endpackage : ccm_pkg

// *** src/ccm_edge_det.sv ***
// ccm_edge_det: registered level and transition detect of a synchronous input
`timescale 1ns/10ps
module ccm_edge_det (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic level_i,
  output logic      prev_o,
  output logic      rise_o,
  output logic      any_o
);

  logic prev_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_i;
    end
  end

  assign prev_o = prev_q;
  assign rise_o = level_i & ~prev_q;
  assign any_o  = level_i ^ prev_q;

endmodule : ccm_edge_det

// *** src/ccm_top.sv ***
// ccm_top: cpu clock source selection, synthesis and input clock monitor
`timescale 1ns/10ps

module ccm_top
  import ccm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] clock_config_pins_i,
  input  wire logic       crystal_input_i,
  input  wire logic       pll_clk_i,
  input  wire logic       osc_monitor_disable_i,
  input  wire logic       irq_clear_i,
  output logic            cpu_clk_o,
  output logic            cpu_edge_o,
  output logic            pll_enable_o,
  output logic            osc_fail_interrupt_o,
  output logic            failover_o,
  output logic [2:0]      clock_config_field_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [2:0]            cfg_q;
  logic                  cfg_taken_q;
  logic [CCM_MON_W-1:0]  mon_q;
  logic [CCM_MON_W-1:0]  mon_d;
  logic                  fail_q;
  logic                  irq_q;
  logic                  cpu_clk_q;
  logic                  cpu_clk_d;
  logic                  edge_q;
  logic                  pll_en_q;
  logic                  pll_en_d;
  logic                  presc_q;
  logic [CCM_PER_W-1:0]  per_cnt_q;
  logic [CCM_PER_W-1:0]  per_q;
  logic [CCM_PER_W:0]    acc_q;
  logic [CCM_PER_W:0]    acc_d;
  logic                  locked_q;

  // ---------------------------------------------------------------------------
  // input transitions
  // ---------------------------------------------------------------------------
  logic xtal_prev;
  logic xtal_rise;
  logic xtal_any;
  logic pll_prev;
  logic pll_rise;
  logic pll_any;

  ccm_edge_det u_xtal_edge (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .level_i (crystal_input_i),
    .prev_o  (xtal_prev),
    .rise_o  (xtal_rise),
    .any_o   (xtal_any)
  );

  ccm_edge_det u_pll_edge (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .level_i (pll_clk_i),
    .prev_o  (pll_prev),
    .rise_o  (pll_rise),
    .any_o   (pll_any)
  );

  // ---------------------------------------------------------------------------
  // configuration capture
  // ---------------------------------------------------------------------------
  // async reset may only load a constant, so the pins are taken on the
  // first edge after release, before any mechanism but the free-running prescaler divider starts
  wire cfg_load = ~cfg_taken_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q       <= CCM_CFG_RESET;
      cfg_taken_q <= 1'b0;
    end else if (cfg_load) begin
      cfg_q       <= clock_config_pins_i;
      cfg_taken_q <= 1'b1;
    end
  end
  // no other path writes cfg_q until the next reset

  // ---------------------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------------------
  ccm_mode_type              mode;
  logic [CCM_HALF_W-1:0]     half_per;

  always_comb begin
    unique case (cfg_q)
      CCM_CFG_MUL4: begin
        mode     = CCM_MODE_MULT;
        half_per = CCM_HALF_MUL4;
      end
      CCM_CFG_MUL3: begin
        mode     = CCM_MODE_MULT;
        half_per = CCM_HALF_MUL3;
      end
      CCM_CFG_MUL2: begin
        mode     = CCM_MODE_MULT;
        half_per = CCM_HALF_MUL2;
      end
      CCM_CFG_MUL5: begin
        mode     = CCM_MODE_MULT;
        half_per = CCM_HALF_MUL5;
      end
      CCM_CFG_MUL1P5: begin
        mode     = CCM_MODE_MULT;
        half_per = CCM_HALF_MUL1P5;
      end
      CCM_CFG_MUL2P5: begin
        mode     = CCM_MODE_MULT;
        half_per = CCM_HALF_MUL2P5;
      end
      CCM_CFG_PRESCALE: begin
        mode     = CCM_MODE_PRESCALE;
        half_per = CCM_HALF_NONE;
      end
      CCM_CFG_DIRECT: begin
        mode     = CCM_MODE_DIRECT;
        half_per = CCM_HALF_NONE;
      end
    endcase
  end

  wire direct_like = (mode == CCM_MODE_DIRECT) | (mode == CCM_MODE_PRESCALE);
  wire mon_active  = cfg_taken_q & direct_like & ~osc_monitor_disable_i & ~fail_q;
  // fifteen quiet pll rises fill the counter; the sixteenth is the overflow
  wire mon_full    = mon_q == (CCM_MON_OVERFLOW - 5'h01);
  wire mon_hit     = mon_active & ~xtal_any & pll_rise & mon_full;
  wire fail_event  = mon_hit & ~fail_q;

  // ---------------------------------------------------------------------------
  // input clock monitor
  // ---------------------------------------------------------------------------
  // an idle or disabled monitor parks at zero, so re-enabling starts afresh
  always_comb begin
    mon_d = mon_q;
    if (!mon_active) begin
      mon_d = CCM_MON_RESET;
    end else if (xtal_any) begin
      mon_d = CCM_MON_RESET;
    end else if (pll_rise) begin
      mon_d = mon_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mon_q <= CCM_MON_RESET;
    end else begin
      mon_q <= mon_d;
    end
  end

  // failover is sticky; only rstn_i returns the input clock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fail_q <= 1'b0;
    end else if (fail_event) begin
      fail_q <= 1'b1;
    end
  end

  // set wins over a clear in the same cycle, so no failure goes unreported
  wire irq_set = fail_event;
  wire irq_clr = irq_clear_i & ~irq_set;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (irq_clr) begin
      irq_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // pll power
  // ---------------------------------------------------------------------------
  // after failover the pll keeps running: it is then the only clock left
  assign pll_en_d = ~cfg_taken_q ? 1'b0 :
                    (mode == CCM_MODE_MULT) ? 1'b1 :
                    (fail_q | ~osc_monitor_disable_i);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_en_q <= 1'b0;
    end else begin
      pll_en_q <= pll_en_d;
    end
  end

  // ---------------------------------------------------------------------------
  // multiplier synthesis
  // ---------------------------------------------------------------------------
  // input period measured in clk_i cycles between rising edges; a phase
  // accumulator spreads 2F half periods over it, so fractional factors
  // need no divider. resolution is limited to one clk_i cycle
  wire [CCM_PER_W:0] acc_sum  = acc_q + {{(CCM_PER_W + 1 - CCM_HALF_W){1'b0}}, half_per};
  wire               acc_wrap = locked_q & (acc_sum >= {1'b0, per_q});
  wire               mul_run  = (mode == CCM_MODE_MULT) & cfg_taken_q;

  assign acc_d = xtal_rise ? {(CCM_PER_W + 1){1'b0}} :
                 acc_wrap  ? (acc_sum - {1'b0, per_q}) : acc_sum;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      per_cnt_q <= CCM_PER_RESET;
      per_q     <= CCM_PER_RESET;
      locked_q  <= 1'b0;
      acc_q     <= {(CCM_PER_W + 1){1'b0}};
    end else if (mul_run) begin
      if (xtal_rise) begin
        per_q     <= per_cnt_q + 16'h0001;
        per_cnt_q <= CCM_PER_RESET;
        locked_q  <= 1'b1;
      end else if (per_cnt_q != CCM_PER_MAX) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
      end
      acc_q <= acc_d;
    end
  end

  // ---------------------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------------------
  // divider runs in every mode; only the select below makes it visible
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_q <= 1'b0;
    end else if (xtal_rise) begin
      presc_q <= ~presc_q;
    end
  end

  // ---------------------------------------------------------------------------
  // cpu clock select
  // ---------------------------------------------------------------------------
  // with the period known, 2F-1 wraps fall between two input rises and the
  // 2F-th lands on the rise itself; the rise toggles too, so odd 2F codes
  // keep their rate and their phase at a rise simply alternates
  wire mul_step  = acc_wrap | xtal_rise;
  wire mul_clk   = mul_step ? ~cpu_clk_q : cpu_clk_q;
  wire presc_clk = xtal_rise ? ~presc_q : presc_q;
  wire src_fail  = fail_q | fail_event;
  wire src_dir   = mode == CCM_MODE_DIRECT;
  wire src_presc = mode == CCM_MODE_PRESCALE;

  assign cpu_clk_d = ~cfg_taken_q ? 1'b0 :
                     src_fail     ? pll_clk_i :
                     src_dir      ? crystal_input_i :
                     src_presc    ? presc_clk :
                     mul_clk;

  // edge mark is registered beside the clock so both change together
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_clk_q <= 1'b0;
      edge_q    <= 1'b0;
    end else begin
      cpu_clk_q <= cpu_clk_d;
      edge_q    <= cpu_clk_d ^ cpu_clk_q;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign cpu_clk_o            = cpu_clk_q;
  assign cpu_edge_o           = edge_q;
  assign pll_enable_o         = pll_en_q;
  assign osc_fail_interrupt_o = irq_q;
  assign failover_o           = fail_q;
  assign clock_config_field_o = cfg_q;

  // unused detector taps kept for symmetry of the two instances
  wire unused_taps = xtal_prev ^ pll_prev ^ pll_any;

endmodule : ccm_top

// *** test/ccm_top_monitor.sv ***
// ccm_top_monitor: concurrent checks on the clock select block ports
`timescale 1ns/10ps
module ccm_top_monitor
  import ccm_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic [2:0] clock_config_pins_i,
  input wire logic       crystal_input_i,
  input wire logic       pll_clk_i,
  input wire logic       osc_monitor_disable_i,
  input wire logic       irq_clear_i,
  input wire logic       cpu_clk_o,
  input wire logic       cpu_edge_o,
  input wire logic       pll_enable_o,
  input wire logic       osc_fail_interrupt_o,
  input wire logic       failover_o,
  input wire logic [2:0] clock_config_field_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic mon_w = (clock_config_field_o == CCM_CFG_DIRECT) ||
                     (clock_config_field_o == CCM_CFG_PRESCALE);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_field_hold: assert property ($past(rstn_i) && $past(rstn_i, 2) |->
    $stable(clock_config_field_o)) else $error("config field moved");
  a_fail_sticky: assert property (failover_o |=> failover_o)
    else $error("failover dropped");
  a_irq_hold: assert property (osc_fail_interrupt_o && !irq_clear_i |=>
    osc_fail_interrupt_o) else $error("request dropped");
  a_fail_irq: assert property ($rose(failover_o) |-> osc_fail_interrupt_o)
    else $error("failover without request");
  a_fail_mode: assert property (!mon_w |-> !failover_o)
    else $error("failover in multiplier mode");
  a_fail_pll_clk: assert property ($past(failover_o) && failover_o |->
    cpu_clk_o == $past(pll_clk_i)) else $error("cpu clock not pll");
  a_direct_copy: assert property ((clock_config_field_o == CCM_CFG_DIRECT) &&
    !failover_o && $past(rstn_i) |=> failover_o || cpu_clk_o == $past(crystal_input_i))
    else $error("direct clock mismatch");
  a_pll_mult: assert property (!mon_w && $past(rstn_i) && $past(rstn_i, 2) |->
    pll_enable_o) else $error("pll off in multiplier mode");
  a_pll_off: assert property (mon_w && osc_monitor_disable_i &&
    $past(osc_monitor_disable_i) && !failover_o && $past(rstn_i) && $past(rstn_i, 2)
    |-> !pll_enable_o) else $error("pll on while monitor off");
  a_edge_mark: assert property (cpu_edge_o == (cpu_clk_o != $past(cpu_clk_o)))
    else $error("edge mark wrong");
  c_fail: cover property ($rose(failover_o));
  c_pre: cover property (clock_config_field_o == CCM_CFG_PRESCALE && cpu_edge_o);
  c_clear: cover property ($fell(osc_fail_interrupt_o));
endmodule : ccm_top_monitor

// *** test/ccm_xtal_model.sv ***
// ccm_xtal_model: oscillator source on the crystal input
`timescale 1ns/10ps
module ccm_xtal_model (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  output logic            xtal_o
);
  int cnt_q = 0;
  initial xtal_o = 1'h0;
  // a dead source stands still, no stray pulses
  always @(posedge clk_i) begin
    if (run_i && cnt_q >= int'(half_i) - 1) begin
      cnt_q  <= 0;
      xtal_o <= #1 ~xtal_o;
    end else if (run_i) begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : ccm_xtal_model

// *** test/tb_top.sv ***
// tb_top: self-checking bench for the cpu clock select block
`timescale 1ns/10ps
module tb_top;
  import ccm_pkg::*;
  logic            clk_i, rstn_i, pll, dis, clr, run, prev;
  logic [2:0]      pins;
  logic [7:0]      half;
  wire logic       xtal, cpu, edg, pllen, irq, fo;
  wire logic [2:0] fld;
  int              error_cnt = 0;
  int              checks = 0;
  ccm_top u_ccm_top (.clk_i(clk_i), .rstn_i(rstn_i), .clock_config_pins_i(pins),
    .crystal_input_i(xtal), .pll_clk_i(pll), .osc_monitor_disable_i(dis),
    .irq_clear_i(clr), .cpu_clk_o(cpu), .cpu_edge_o(edg), .pll_enable_o(pllen),
    .osc_fail_interrupt_o(irq), .failover_o(fo), .clock_config_field_o(fld));
  ccm_xtal_model u_ccm_xtal_model (.clk_i(clk_i), .run_i(run), .half_i(half),
    .xtal_o(xtal));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // free-running pll: one rise every two system clocks
  always @(posedge clk_i) pll <= #1 ~pll;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  task automatic do_reset(input logic [2:0] code);
    rstn_i = 1'h0;
    pins = code;
    tick(12);
    rstn_i = 1'h1;
    tick(2);
    check(fld, code);
    pins = ~code;
    tick(4);
    check(fld, code);
  endtask : do_reset
  task automatic test_mult();
    logic [2:0] codes [6] = '{CCM_CFG_MUL4, CCM_CFG_MUL3, CCM_CFG_MUL2,
                             CCM_CFG_MUL5, CCM_CFG_MUL1P5, CCM_CFG_MUL2P5};
    logic [3:0] hv [6] = '{CCM_HALF_MUL4, CCM_HALF_MUL3, CCM_HALF_MUL2,
                          CCM_HALF_MUL5, CCM_HALF_MUL1P5, CCM_HALF_MUL2P5};
    int n;
    half = 8'h3C;
    for (int i = 0; i < 6; i++) begin
      do_reset(codes[i]);
      check(pllen, 1'h1);
      repeat (3) @(posedge xtal);
      n = 0;
      // one input period; resync jitter allows one edge either way
      repeat (120) begin
        tick(1);
        n += int'(edg);
      end
      check(n >= int'(hv[i]) - 1 && n <= int'(hv[i]) + 1, 1'h1);
      run = 1'h0;
      tick(60);
      check(fo, 1'h0);
      run = 1'h1;
    end
    $display("test_mult done");
  endtask : test_mult
  task automatic test_direct();
    half = 8'h04;
    do_reset(CCM_CFG_DIRECT);
    check(pllen, 1'h1);
    repeat (20) begin
      prev = xtal;
      tick(1);
      check(cpu, prev);
    end
    // 24-cycle gaps hold only 12 pll rises: only clearing keeps it alive
    half = 8'h18;
    tick(100);
    check(fo, 1'h0);
    half = 8'h04;
    tick(8);
    run = 1'h0;
    tick(20);
    check(fo, 1'h0);
    tick(20);
    check(fo, 1'h1);
    check(irq, 1'h1);
    run = 1'h1;
    tick(20);
    check(fo, 1'h1);
    check(irq, 1'h1);
    prev = pll;
    tick(1);
    check(cpu, prev);
    clr = 1'h1;
    tick(1);
    clr = 1'h0;
    check(irq, 1'h0);
    $display("test_direct done");
  endtask : test_direct
  task automatic test_prescale();
    int n;
    do_reset(CCM_CFG_PRESCALE);
    n = 0;
    repeat (80) begin
      tick(1);
      n += int'(edg);
    end
    check(n >= 9 && n <= 11, 1'h1);
    dis = 1'h1;
    tick(3);
    check(pllen, 1'h0);
    run = 1'h0;
    tick(60);
    check(fo, 1'h0);
    dis = 1'h0;
    tick(40);
    check(fo, 1'h1);
    run = 1'h1;
    $display("test_prescale done");
  endtask : test_prescale
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    rstn_i = 1'h0;
    pins = CCM_CFG_RESET;
    pll = 1'h0;
    dis = 1'h0;
    clr = 1'h0;
    run = 1'h1;
    half = 8'h3C;
    test_mult();
    test_direct();
    test_prescale();
    print_verdict();
  end
  initial begin
    #200000;
    error_cnt++;
    $display("Error %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_top
bind ccm_top ccm_top_monitor u_ccm_top_monitor (.clk_i(clk_i), .rstn_i(rstn_i),
  .clock_config_pins_i(clock_config_pins_i), .crystal_input_i(crystal_input_i),
  .pll_clk_i(pll_clk_i), .osc_monitor_disable_i(osc_monitor_disable_i),
  .irq_clear_i(irq_clear_i), .cpu_clk_o(cpu_clk_o), .cpu_edge_o(cpu_edge_o),
  .pll_enable_o(pll_enable_o), .osc_fail_interrupt_o(osc_fail_interrupt_o),
  .failover_o(failover_o), .clock_config_field_o(clock_config_field_o));
